// [verilog/ocr_top.sv]
// On-chip RAM access logic: plain parity region and corrected region
//
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "ocr_consts.svh"

module ocr_top (
    input  wire logic               clock_i,
    input  wire logic               reset_i,
    input  wire ocr_pkg::ocr_mreq_s mem_req_i,
    output var  ocr_pkg::ocr_mrsp_s mem_rsp_o,
    input  wire logic               s_axi_awvalid_i,
    output logic                    s_axi_awready_o,
    input  wire logic [7:0]         s_axi_awaddr_i,
    input  wire logic               s_axi_wvalid_i,
    output logic                    s_axi_wready_o,
    input  wire logic [31:0]        s_axi_wdata_i,
    input  wire logic [3:0]         s_axi_wstrb_i,
    output logic                    s_axi_bvalid_o,
    input  wire logic               s_axi_bready_i,
    output logic [1:0]              s_axi_bresp_o,
    input  wire logic               s_axi_arvalid_i,
    output logic                    s_axi_arready_o,
    input  wire logic [7:0]         s_axi_araddr_i,
    output logic                    s_axi_rvalid_o,
    input  wire logic               s_axi_rready_i,
    output logic [31:0]             s_axi_rdata_o,
    output logic [1:0]              s_axi_rresp_o,
    output logic                    irq_o,
    output logic                    nmi_o
);
    import ocr_pkg::*;

    function automatic logic [38:0] ecc_enc(input logic [31:0] d);
        logic [38:0] cw;
        int          j;
        cw = '0;
        j = 0;
        for (int p = 1; p < 39; p++) begin
            if ((p & (p - 1)) != 0) begin
                cw[p] = d[j];
                j++;
            end
        end
        for (int k = 0; k < 6; k++) begin
            for (int p = 1; p < 39; p++) begin
                if (((p >> k) & 1) == 1 && p != (1 << k)) begin
                    cw[1 << k] = cw[1 << k] ^ cw[p];
                end
            end
        end
        cw[0] = ^cw[38:1];
        return cw;
    endfunction

    // Correction applied only when fix is set
    function automatic ocr_dec_s ecc_dec(input logic [38:0] cw,
                                         input logic        fix);
        ocr_dec_s    r;
        logic [5:0]  s;
        logic [38:0] fx;
        logic        odd;
        int          j;
        s = '0;
        for (int k = 0; k < 6; k++) begin
            for (int p = 1; p < 39; p++) begin
                if (((p >> k) & 1) == 1) begin
                    s[k] = s[k] ^ cw[p];
                end
            end
        end
        odd = ^cw;
        r.single = odd && (s < 6'h27);
        r.double = (odd && (s > 6'h26)) || (!odd && (s != 6'h00));
        fx = cw;
        if (fix && r.single) begin
            fx[s] = ~fx[s];
        end
        r.data = '0;
        j = 0;
        for (int p = 1; p < 39; p++) begin
            if ((p & (p - 1)) != 0) begin
                r.data[j] = fx[p];
                j++;
            end
        end
        return r;
    endfunction

    function automatic logic [35:0] par_enc(input logic [31:0] d);
        logic [35:0] w;
        for (int l = 0; l < 4; l++) begin
            w[l*9 +: 9] = {^d[l*8 +: 8], d[l*8 +: 8]};
        end
        return w;
    endfunction

    function automatic logic par_bad(input logic [35:0] w);
        logic b;
        b = 1'b0;
        for (int l = 0; l < 4; l++) begin
            b = b | (^w[l*9 +: 9]);
        end
        return b;
    endfunction

    function automatic logic [31:0] par_data(input logic [35:0] w);
        logic [31:0] d;
        for (int l = 0; l < 4; l++) begin
            d[l*8 +: 8] = w[l*9 +: 8];
        end
        return d;
    endfunction

    function automatic logic [2:0] lat_f(input logic ws, input logic on,
                                         input logic err, input logic wr);
        logic [2:0] n;
        if (!ws) begin
            n = !on ? `OCR_LAT_W0_OFF : (err ? `OCR_LAT_W0_ERR : `OCR_LAT_W0_OK);
        end else if (!on) begin
            n = `OCR_LAT_W1_OFF;
        end else if (err) begin
            n = `OCR_LAT_W1_ERR;
        end else begin
            n = wr ? `OCR_LAT_W1_WR_OK : `OCR_LAT_W1_RD_OK;
        end
        return n;
    endfunction

    // Software-visible state
    logic [8:0]  ctrl_q, ctrl_d;
    logic [2:0]  mask_q, mask_d;
    logic [2:0]  st_q, st_d;
    logic [31:0] pea_q, pea_d;
    logic [31:0] e1a_q, e1a_d;
    logic [31:0] e2a_q, e2a_d;
    // Access sequencer state
    ocr_state_e  state_q, state_d;
    ocr_mreq_s   op_q, op_d;
    logic        ws_q, ws_d;
    logic        on_q, on_d;
    logic        refuse_q, refuse_d;
    logic        err_q, err_d;
    logic        eerr_q, eerr_d;
    logic [2:0]  cnt_q, cnt_d;
    logic [31:0] rdat_q, rdat_d;
    // Register bus state
    logic        awh_q, awh_d;
    logic [7:0]  awa_q, awa_d;
    logic        wh_q, wh_d;
    logic [31:0] wd_q, wd_d;
    logic        ws0_q, ws0_d;
    logic        bv_q, bv_d;
    logic [1:0]  br_q, br_d;
    logic        rv_q, rv_d;
    logic [31:0] rd_q, rd_d;
    logic [1:0]  rr_q, rr_d;

    logic        take, in_plain, in_ecc, plain_ok, ecc_ok, ack, full;
    logic        plain_perr, ecc_ev, do_wr, do_rd;
    logic [2:0]  ev, clr;
    logic [3:0]  plain_we;
    logic [35:0] plain_q;
    logic [38:0] ecc_q;
    logic [11:0] ecc_addr;
    logic [31:0] merged;
    ocr_dec_s    dec;

    assign take     = (state_q == ST_IDLE) && mem_req_i.req;
    assign in_plain = mem_req_i.addr < (ctrl_q[`OCR_CTRL_SIZE_128K] ?
                      `OCR_PLAIN_TOP_128K : `OCR_PLAIN_TOP_64K);
    assign in_ecc   = mem_req_i.addr[31:14] == `OCR_ECC_HI;
    assign plain_ok = in_plain && ctrl_q[`OCR_CTRL_PLAIN_EN]
                      && !ctrl_q[`OCR_CTRL_PLAIN_STP];
    assign ecc_ok   = in_ecc && !ctrl_q[`OCR_CTRL_ECC_STP];
    assign plain_we = (take && plain_ok && mem_req_i.we) ? mem_req_i.be : 4'h0;
    assign ecc_addr = (state_q == ST_IDLE) ? mem_req_i.addr[13:2]
                                           : op_q.addr[13:2];
    assign dec      = ecc_dec(ecc_q, on_q);
    assign full     = op_q.be == 4'hF;
    always_comb begin
        for (int l = 0; l < 4; l++) begin
            merged[l*8 +: 8] = op_q.be[l] ? op_q.wdata[l*8 +: 8]
                                          : dec.data[l*8 +: 8];
        end
    end

    ocr_mem #(
        .LANES (4),
        .LW    (9),
        .AW    (15)
    ) u_plain (
        .clock_i (clock_i),
        .reset_i (reset_i),
        .we_i    (plain_we),
        .addr_i  (mem_req_i.addr[16:2]),
        .wdata_i (par_enc(mem_req_i.wdata)
                  ^ {27'h0, ctrl_q[`OCR_CTRL_INJ1], 8'h00}),
        .rdata_o (plain_q)
    );

    ocr_mem #(
        .LANES (1),
        .LW    (39),
        .AW    (12)
    ) u_ecc (
        .clock_i (clock_i),
        .reset_i (reset_i),
        .we_i    ((state_q == ST_ECC_CHK) && op_q.we),
        .addr_i  (ecc_addr),
        .wdata_i (ecc_enc(merged) ^ {37'h0, ctrl_q[`OCR_CTRL_INJ2],
                                     ctrl_q[`OCR_CTRL_INJ1]}),
        .rdata_o (ecc_q)
    );

    assign plain_perr = (state_q == ST_PLAIN) && !refuse_q && !op_q.we
                        && par_bad(plain_q);
    assign ecc_ev = (state_q == ST_ECC_CHK) && on_q && (!op_q.we || !full)
                    && (dec.single || dec.double);
    assign ev  = {ecc_ev && dec.double, ecc_ev && dec.single, plain_perr};
    assign ack = (state_q == ST_PLAIN)
                 || ((state_q == ST_ECC_HOLD) && (cnt_q == 3'h0));

    always_comb begin
        mem_rsp_o.ack   = ack;
        mem_rsp_o.err   = (state_q == ST_PLAIN) ? (refuse_q || plain_perr)
                                                : (ack && err_q);
        mem_rsp_o.rdata = ((state_q == ST_PLAIN) && !refuse_q)
                          ? par_data(plain_q) : rdat_q;
    end

    always_comb begin
        state_d  = state_q;
        op_d     = op_q;
        ws_d     = ws_q;
        on_d     = on_q;
        refuse_d = refuse_q;
        err_d    = err_q;
        eerr_d   = eerr_q;
        cnt_d    = cnt_q;
        rdat_d   = rdat_q;
        case (state_q)
            ST_IDLE: begin
                if (take) begin
                    op_d     = mem_req_i;
                    ws_d     = ctrl_q[`OCR_CTRL_WAIT_SEL];
                    on_d     = ctrl_q[`OCR_CTRL_ECC_ON];
                    refuse_d = !plain_ok && !ecc_ok;
                    state_d  = ecc_ok ? ST_ECC_CHK : ST_PLAIN;
                end
            end
            ST_PLAIN: begin
                state_d = ST_IDLE;
            end
            ST_ECC_CHK: begin
                rdat_d  = dec.data;
                err_d   = ecc_ev && dec.double;
                eerr_d  = ecc_ev;
                cnt_d   = lat_f(ws_q, on_q, ecc_ev, op_q.we) - 3'h2;
                state_d = ST_ECC_HOLD;
            end
            ST_ECC_HOLD: begin
                if (cnt_q == 3'h0) begin
                    state_d = ST_IDLE;
                end else begin
                    cnt_d = cnt_q - 3'h1;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            state_q  <= ST_IDLE;
            op_q     <= '0;
            ws_q     <= 1'b0;
            on_q     <= 1'b0;
            refuse_q <= 1'b0;
            err_q    <= 1'b0;
            eerr_q   <= 1'b0;
            cnt_q    <= 3'h0;
            rdat_q   <= 32'h0000_0000;
        end else begin
            state_q  <= state_d;
            op_q     <= op_d;
            ws_q     <= ws_d;
            on_q     <= on_d;
            refuse_q <= refuse_d;
            err_q    <= err_d;
            eerr_q   <= eerr_d;
            cnt_q    <= cnt_d;
            rdat_q   <= rdat_d;
        end
    end

    // AXI4-Lite slave
    assign do_wr = awh_q && wh_q && !bv_q;
    assign do_rd = s_axi_arvalid_i && !rv_q;
    assign clr   = (do_rd && (s_axi_araddr_i == `OCR_OFF_STAT)) ? 3'h7 : 3'h0;

    always_comb begin
        awh_d  = awh_q;
        awa_d  = awa_q;
        wh_d   = wh_q;
        wd_d   = wd_q;
        ws0_d  = ws0_q;
        bv_d   = bv_q && !s_axi_bready_i;
        br_d   = br_q;
        rv_d   = rv_q && !s_axi_rready_i;
        rd_d   = rd_q;
        rr_d   = rr_q;
        ctrl_d = ctrl_q;
        mask_d = mask_q;
        if (s_axi_awvalid_i && !awh_q) begin
            awh_d = 1'b1;
            awa_d = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && !wh_q) begin
            wh_d  = 1'b1;
            wd_d  = s_axi_wdata_i;
            ws0_d = s_axi_wstrb_i[0];
        end
        if (do_wr) begin
            awh_d = 1'b0;
            wh_d  = 1'b0;
            bv_d  = 1'b1;
            br_d  = `OCR_RESP_OKAY;
            case (awa_q)
                `OCR_OFF_CTRL: if (ws0_q) ctrl_d = wd_q[8:0];
                `OCR_OFF_MASK: if (ws0_q) mask_d = wd_q[2:0];
                `OCR_OFF_STAT, `OCR_OFF_PLAIN_EA,
                `OCR_OFF_ECC1_EA, `OCR_OFF_ECC2_EA: br_d = `OCR_RESP_OKAY;
                default: br_d = `OCR_RESP_SLVERR;
            endcase
        end
        if (do_rd) begin
            rv_d = 1'b1;
            rr_d = `OCR_RESP_OKAY;
            case (s_axi_araddr_i)
                `OCR_OFF_CTRL:     rd_d = {23'h0, ctrl_q};
                `OCR_OFF_STAT:     rd_d = {29'h0, st_q};
                `OCR_OFF_MASK:     rd_d = {29'h0, mask_q};
                `OCR_OFF_PLAIN_EA: rd_d = pea_q;
                `OCR_OFF_ECC1_EA:  rd_d = e1a_q;
                `OCR_OFF_ECC2_EA:  rd_d = e2a_q;
                default: begin
                    rd_d = 32'h0000_0000;
                    rr_d = `OCR_RESP_SLVERR;
                end
            endcase
        end
    end

    // Sticky flags, set beats read-clear; address held while flag is up
    always_comb begin
        st_d  = (st_q & ~clr) | ev;
        pea_d = (ev[0] && (!st_q[0] || clr[0])) ? op_q.addr : pea_q;
        e1a_d = (ev[1] && (!st_q[1] || clr[1])) ? op_q.addr : e1a_q;
        e2a_d = (ev[2] && (!st_q[2] || clr[2])) ? op_q.addr : e2a_q;
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            awh_q  <= 1'b0;
            awa_q  <= 8'h00;
            wh_q   <= 1'b0;
            wd_q   <= 32'h0000_0000;
            ws0_q  <= 1'b0;
            bv_q   <= 1'b0;
            br_q   <= 2'h0;
            rv_q   <= 1'b0;
            rd_q   <= 32'h0000_0000;
            rr_q   <= 2'h0;
            ctrl_q <= `OCR_CTRL_RST;
            mask_q <= `OCR_MASK_RST;
            st_q   <= 3'h0;
            pea_q  <= 32'h0000_0000;
            e1a_q  <= 32'h0000_0000;
            e2a_q  <= 32'h0000_0000;
        end else begin
            awh_q  <= awh_d;
            awa_q  <= awa_d;
            wh_q   <= wh_d;
            wd_q   <= wd_d;
            ws0_q  <= ws0_d;
            bv_q   <= bv_d;
            br_q   <= br_d;
            rv_q   <= rv_d;
            rd_q   <= rd_d;
            rr_q   <= rr_d;
            ctrl_q <= ctrl_d;
            mask_q <= mask_d;
            st_q   <= st_d;
            pea_q  <= pea_d;
            e1a_q  <= e1a_d;
            e2a_q  <= e2a_d;
        end
    end

    assign s_axi_awready_o = !awh_q;
    assign s_axi_wready_o  = !wh_q;
    assign s_axi_bvalid_o  = bv_q;
    assign s_axi_bresp_o   = br_q;
    assign s_axi_arready_o = !rv_q;
    assign s_axi_rvalid_o  = rv_q;
    assign s_axi_rdata_o   = rd_q;
    assign s_axi_rresp_o   = rr_q;
    assign irq_o = (|(st_q & mask_q)) && !ctrl_q[`OCR_CTRL_NMI_ROUTE];
    assign nmi_o = (|st_q) && ctrl_q[`OCR_CTRL_NMI_ROUTE];

    // Cycles since the access was taken, for checking only
    logic [2:0] acc_q, acc_d;
    always_comb begin
        acc_d = take ? 3'h1 : ((state_q != ST_IDLE) ? acc_q + 3'h1 : 3'h0);
    end
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            acc_q <= 3'h0;
        end else begin
            acc_q <= acc_d;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);

    logic ecc_ack;
    assign ecc_ack = ack && (state_q == ST_ECC_HOLD);

    AST_PLAIN_ONE: assert property (
        take && plain_ok |-> ##1 (ack && state_q == ST_PLAIN) ##1 !ack)
        else $error("plain access did not finish in one cycle");
    AST_W0_OFF: assert property (
        ecc_ack && !ws_q && !on_q |-> acc_q == 3'h2)
        else $error("wait 0 correction off latency wrong");
    AST_W0_OK: assert property (
        ecc_ack && !ws_q && on_q && !eerr_q |-> acc_q == 3'h2)
        else $error("wait 0 clean latency wrong");
    AST_W0_ERR: assert property (
        ecc_ack && !ws_q && on_q && eerr_q |-> acc_q == 3'h3)
        else $error("wait 0 error latency wrong");
    AST_W1_OFF: assert property (
        take && ecc_ok && ctrl_q[`OCR_CTRL_WAIT_SEL]
        && !ctrl_q[`OCR_CTRL_ECC_ON] |-> ##1 !ack [*2] ##1 ack)
        else $error("wait 1 correction off latency wrong");
    AST_W1_OK: assert property (
        ecc_ack && ws_q && on_q && !eerr_q
        |-> acc_q == (op_q.we ? 3'h4 : 3'h3))
        else $error("wait 1 clean latency wrong");
    AST_W1_ERR: assert property (
        ecc_ack && ws_q && on_q && eerr_q |-> acc_q == 3'h5)
        else $error("wait 1 error latency wrong");
    AST_ECC_RANGE: assert property (
        take && in_ecc && !ctrl_q[`OCR_CTRL_ECC_STP]
        |-> ##1 state_q == ST_ECC_CHK)
        else $error("corrected region not selected");
    AST_DOUBLE_ERR: assert property (
        ev[2] && !op_q.we |-> ##[1:4] (ack && mem_rsp_o.err))
        else $error("double error not reported");
    AST_PLAIN_FLAG: assert property (
        plain_perr |-> ##1 st_q[`OCR_STAT_PLAIN])
        else $error("plain error flag not set");
    AST_IRQ: assert property (
        plain_perr && mask_q[0] && !ctrl_q[`OCR_CTRL_NMI_ROUTE]
        |-> ##1 irq_o)
        else $error("interrupt not raised");
    AST_REFUSE: assert property (
        take && in_plain && !ctrl_q[`OCR_CTRL_PLAIN_EN]
        |-> ##1 (ack && mem_rsp_o.err))
        else $error("disabled region access not refused");
    AST_STOP: assert property (
        take && in_ecc && ctrl_q[`OCR_CTRL_ECC_STP]
        |-> ##1 (ack && mem_rsp_o.err))
        else $error("stopped region access not refused");
    AST_CAPTURE: assert property (
        $rose(st_q[`OCR_STAT_PLAIN]) |-> pea_q == $past(op_q.addr))
        else $error("failing address not captured");

    COV_PLAIN: cover property (take && plain_ok ##1 ack);
    COV_ECC_SINGLE: cover property (ev[1] ##[1:4] ack);
    COV_W1_WRITE: cover property (ecc_ack && ws_q && on_q && op_q.we);
    COV_NMI: cover property (nmi_o);
endmodule
`default_nettype wire

// [inc/ocr_consts.svh]
// Register offsets, field positions, reset values and access latencies
`ifndef OCR_CONSTS_SVH
`define OCR_CONSTS_SVH

`define OCR_OFF_CTRL       8'h00
`define OCR_OFF_STAT       8'h04
`define OCR_OFF_MASK       8'h08
`define OCR_OFF_PLAIN_EA   8'h0C
`define OCR_OFF_ECC1_EA    8'h10
`define OCR_OFF_ECC2_EA    8'h14

`define OCR_CTRL_PLAIN_EN  0
`define OCR_CTRL_PLAIN_STP 1
`define OCR_CTRL_ECC_ON    2
`define OCR_CTRL_ECC_STP   3
`define OCR_CTRL_WAIT_SEL  4
`define OCR_CTRL_SIZE_128K 5
`define OCR_CTRL_NMI_ROUTE 6
// Self-test hooks: corrupt stored check bits on write
`define OCR_CTRL_INJ1      7
`define OCR_CTRL_INJ2      8
`define OCR_CTRL_RST       9'h005

`define OCR_STAT_PLAIN     0
`define OCR_STAT_ECC1      1
`define OCR_STAT_ECC2      2
`define OCR_MASK_RST       3'h0

`define OCR_PLAIN_TOP_64K  32'h0001_0000
`define OCR_PLAIN_TOP_128K 32'h0002_0000
`define OCR_ECC_HI         18'h003FF

`define OCR_LAT_W0_OFF     3'h2
`define OCR_LAT_W0_OK      3'h2
`define OCR_LAT_W0_ERR     3'h3
`define OCR_LAT_W1_OFF     3'h3
`define OCR_LAT_W1_RD_OK   3'h3
`define OCR_LAT_W1_WR_OK   3'h4
`define OCR_LAT_W1_ERR     3'h5

`define OCR_RESP_OKAY      2'h0
`define OCR_RESP_SLVERR    2'h2

`endif

// [inc/ocr_pkg.sv]
// Types shared by the on-chip RAM access logic
package ocr_pkg;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [31:0] addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } ocr_mreq_s;

    typedef struct packed {
        logic        ack;
        logic        err;
        logic [31:0] rdata;
    } ocr_mrsp_s;

    typedef struct packed {
        logic [31:0] data;
        logic        single;
        logic        double;
    } ocr_dec_s;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_PLAIN,
        ST_ECC_CHK,
        ST_ECC_HOLD
    } ocr_state_e;

endpackage

// [verilog/ocr_mem.sv]
// Word memory with lane write enables and a registered read port
`timescale 1ns/10ps
`default_nettype none
module ocr_mem #(
    parameter int LANES = 4,
    parameter int LW    = 9,
    parameter int AW    = 15
) (
    input  wire logic                clock_i,
    input  wire logic                reset_i,
    input  wire logic [LANES-1:0]    we_i,
    input  wire logic [AW-1:0]       addr_i,
    input  wire logic [LANES*LW-1:0] wdata_i,
    output logic      [LANES*LW-1:0] rdata_o
);
    logic [LANES*LW-1:0] mem_q [2**AW];
    logic [LANES*LW-1:0] rdata_d;
    logic [LANES*LW-1:0] rdata_q;

    always_comb begin
        rdata_d = mem_q[addr_i];
    end

    always_ff @(posedge clock_i) begin
        for (int l = 0; l < LANES; l++) begin
            if (we_i[l]) begin
                mem_q[addr_i][l*LW +: LW] <= wdata_i[l*LW +: LW];
            end
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata_o = rdata_q;
endmodule
`default_nettype wire

// [tb/ocr_cpu_model.sv]
// Memory bus master model for the on-chip RAM block
`timescale 1ns/10ps
`default_nettype none
module ocr_cpu_model (
    input  wire logic               clock_i,
    input  wire ocr_pkg::ocr_mrsp_s rsp_i,
    output var  ocr_pkg::ocr_mreq_s req_o
);
    import ocr_pkg::*;
    initial req_o = '0;
    // One word access; request held until ack, then dropped at once
    task automatic access(input logic w, input logic [31:0] a, d,
                          output logic [31:0] q, output logic e,
                          output int n);
        n = 0;
        @(posedge clock_i);
        req_o <= '{req: 1'h1, we: w, addr: a, be: 4'hF, wdata: d};
        @(posedge clock_i);
        do begin
            @(posedge clock_i);
            n++;
        end while (rsp_i.ack !== 1'h1 && n < 20);
        q = rsp_i.rdata;
        e = rsp_i.err;
        // Released bus shows no stale address or data
        req_o <= '{req: 1'h0, we: ~w, addr: ~a, be: 4'h0, wdata: ~d};
    endtask
endmodule
`default_nettype wire

// [tb/ocr_top_tb.sv]
// Self-checking bench for the on-chip RAM access logic
`timescale 1ns/10ps
`default_nettype none
`include "ocr_consts.svh"
module ocr_top_tb;
    import ocr_pkg::*;
    logic        clock_i = 1'h0;
    logic        reset_i = 1'h1;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic        arvalid = 1'h0, rready = 1'h0;
    logic        awready, wready, bvalid, arready, rvalid, irq, nmi, e;
    logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata, q;
    logic [3:0]  wstrb = 4'hF;
    logic [1:0]  bresp, rresp;
    ocr_mreq_s   mreq;
    ocr_mrsp_s   mrsp;
    int          error_cnt = 0, samples_checked = 0, n;

    always #2 clock_i = ~clock_i;

    ocr_top ocr_top_inst (.clock_i(clock_i), .reset_i(reset_i),
        .mem_req_i(mreq), .mem_rsp_o(mrsp),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_awaddr_i(awaddr), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(wstrb), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_bresp_o(bresp),
        .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .irq_o(irq), .nmi_o(nmi));
    ocr_cpu_model ocr_cpu_model_inst (.clock_i(clock_i), .rsp_i(mrsp),
        .req_o(mreq));

    task automatic chk(input string s, input logic [31:0] g, x);
        samples_checked++;
        if (g !== x) begin
            error_cnt++;
            $display("FAIL %s exp %h got %h", s, x, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        awvalid <= 1'h1;
        awaddr  <= a;
        wvalid  <= 1'h1;
        wdata   <= d;
        bready  <= 1'h1;
        do begin
            @(posedge clock_i);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (bvalid !== 1'h1);
        bready <= 1'h0;
        chk("bresp", {30'h0, bresp}, 32'h0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [1:0] xr,
                      input logic [31:0] x);
        @(posedge clock_i);
        arvalid <= 1'h1;
        araddr  <= a;
        rready  <= 1'h1;
        do begin
            @(posedge clock_i);
            if (arready) arvalid <= 1'h0;
        end while (rvalid !== 1'h1);
        rready <= 1'h0;
        chk("rresp", {30'h0, rresp}, {30'h0, xr});
        chk("rdata", rdata, x);
    endtask

    // Memory access with expected error flag and ack cycle count
    task automatic mem(input logic w, input logic [31:0] a, d,
                       input logic xe, input logic [31:0] xn);
        ocr_cpu_model_inst.access(w, a, d, q, e, n);
        chk("ack cycles", 32'(n), xn);
        chk("err", {31'h0, e}, {31'h0, xe});
        if (!w && !xe) chk("mem rdata", q, d);
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        #100000;
        error_cnt++;
        conclude();
    end

    initial begin
        repeat (2) @(posedge clock_i);
        reset_i <= 1'h0;
        rd(`OCR_OFF_CTRL, 2'h0, 32'h5);
        rd(`OCR_OFF_STAT, 2'h0, 32'h0);
        rd(8'h18, 2'h2, 32'h0);
        wr(`OCR_OFF_MASK, 32'h7);
        rd(`OCR_OFF_MASK, 2'h0, 32'h7);
        mem(1'h1, 32'h0000_FFFC, 32'hA5A5_1234, 1'h0, 32'h1);
        mem(1'h0, 32'h0000_FFFC, 32'hA5A5_1234, 1'h0, 32'h1);
        mem(1'h1, 32'h0001_0000, 32'h1, 1'h1, 32'h1);
        wr(`OCR_OFF_CTRL, 32'h25);
        mem(1'h1, 32'h0001_FFFC, 32'h5A5A_C3C3, 1'h0, 32'h1);
        mem(1'h0, 32'h0001_FFFC, 32'h5A5A_C3C3, 1'h0, 32'h1);
        mem(1'h1, 32'h0002_0000, 32'h1, 1'h1, 32'h1);
        wr(`OCR_OFF_CTRL, 32'h24);
        mem(1'h0, 32'h0000_0000, 32'h0, 1'h1, 32'h1);
        wr(`OCR_OFF_CTRL, 32'h07);
        mem(1'h0, 32'h0000_0000, 32'h0, 1'h1, 32'h1);
        mem(1'h1, 32'h00FF_FFFC, 32'h0F0F_F0F0, 1'h0, 32'h2);
        mem(1'h0, 32'h00FF_FFFC, 32'h0F0F_F0F0, 1'h0, 32'h2);
        mem(1'h1, 32'h00FF_BFFC, 32'h1, 1'h1, 32'h1);
        wr(`OCR_OFF_CTRL, 32'h0D);
        mem(1'h0, 32'h00FF_C000, 32'h0, 1'h1, 32'h1);
        mem(1'h1, 32'h0000_0010, 32'h77, 1'h0, 32'h1);
        for (int k = 0; k < 4; k++) begin
            wr(`OCR_OFF_CTRL, {26'h0, 1'h0, k[1], 1'h0, k[0], 2'h1});
            mem(1'h1, 32'h00FF_C000 + 4 * k, 32'hC0DE_0000 + k, 1'h0,
                k[1] ? (k[0] ? 32'h4 : 32'h3) : 32'h2);
            mem(1'h0, 32'h00FF_C000 + 4 * k, 32'hC0DE_0000 + k, 1'h0,
                k[1] ? 32'h3 : 32'h2);
        end
        chk("irq", {31'h0, irq}, 32'h0);
        chk("nmi", {31'h0, nmi}, 32'h0);
        rd(`OCR_OFF_STAT, 2'h0, 32'h0);
        wr(`OCR_OFF_CTRL, 32'h85);
        mem(1'h1, 32'h00FF_C100, 32'h1234_5678, 1'h0, 32'h2);
        mem(1'h1, 32'h0000_0020, 32'h0BAD_F00D, 1'h0, 32'h1);
        wr(`OCR_OFF_CTRL, 32'h05);
        mem(1'h0, 32'h00FF_C100, 32'h1234_5678, 1'h0, 32'h3);
        mem(1'h0, 32'h0000_0020, 32'h0, 1'h1, 32'h1);
        rd(`OCR_OFF_PLAIN_EA, 2'h0, 32'h20);
        chk("irq", {31'h0, irq}, 32'h1);
        rd(`OCR_OFF_ECC1_EA, 2'h0, 32'h00FF_C100);
        rd(`OCR_OFF_STAT, 2'h0, 32'h3);
        chk("irq", {31'h0, irq}, 32'h0);
        wr(`OCR_OFF_CTRL, 32'h195);
        mem(1'h1, 32'h00FF_C200, 32'h0, 1'h0, 32'h4);
        wr(`OCR_OFF_CTRL, 32'h55);
        mem(1'h0, 32'h00FF_C200, 32'h0, 1'h1, 32'h5);
        chk("nmi", {31'h0, nmi}, 32'h1);
        chk("irq", {31'h0, irq}, 32'h0);
        rd(`OCR_OFF_ECC2_EA, 2'h0, 32'h00FF_C200);
        rd(`OCR_OFF_STAT, 2'h0, 32'h4);
        chk("nmi", {31'h0, nmi}, 32'h0);
        conclude();
    end
endmodule
`default_nettype wire
